// ---- src/pbs_pkg.sv ----
// Shared constants for the pipelined burst memory port and its controller.
// Assumes a single 10 MHz clock; both ends compile against this package.
// Summary of operation
// - Address captured on load, hold low, selected
// - Low two address bits seed burst counter
// - Word is four nine-bit byte lanes
// - Controller drives byte selects on load writes
// - Controller drives byte selects on advance writes
// - Byte selects ignored on read cycles
// - Write data committed two cycles after command
// - Each byte select gates its own lane
// - Byte selects may stay low for full words
// - Clock hold high freezes the whole device
// - Controller holds clock hold low to advance
// - Load cycle direction applies to whole burst
// - Data moves two cycles after its command
// - Rising edge timing except enable and order
// - Inactive select with load starts deselect
// - Data bus released two cycles after deselect
// - Advance steps counter, ignores address and direction
// - Order pin high interleaved, low linear
// - Output enable high forces data pins off
package pbs_pkg;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int DATA_W = LANE_W * LANES;
    localparam int MEM_AW = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int BURST_LEN = 4;
    localparam int CNT_W = 2;
    localparam int DATA_LAT = 2;
    localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;
    localparam logic [CNT_W-1:0] CNT_START = 2'h0;
    localparam logic ORDER_INTERLEAVED = 1'h1;
    localparam logic SELECT_IDLE_N = 1'h1;
    localparam logic HOLD_RUN = 1'h0;
endpackage

// ---- src/pbs_link_if.sv ----
// Pin bundle between the memory controller and the burst memory port.
// Resolves the shared data lanes from the two output enables.
`timescale 1ns/100ps
interface pbs_link_if #(
    parameter int ADDR_W = pbs_pkg::ADDR_W,
    parameter int DATA_W = pbs_pkg::DATA_W,
    parameter int LANES = pbs_pkg::LANES
);
    logic [ADDR_W-1:0] addr;
    logic wr_n;
    logic burst_advance_or_load;
    logic chip_select_n;
    logic chip_select_high;
    logic chip_select_third_n;
    logic clock_hold_n;
    logic out_enable_n;
    logic burst_order;
    logic [LANES-1:0] byte_write_lane_n;
    logic [DATA_W-1:0] ctl_data;
    logic ctl_data_oe;
    logic [DATA_W-1:0] mem_data;
    logic mem_data_oe;
    logic [DATA_W-1:0] data_bus;

    // Undriven bus reads as zero; contention favours the memory
    assign data_bus = mem_data_oe ? mem_data :
                      (ctl_data_oe ? ctl_data : '0);

    modport ctl (
        output addr, wr_n, burst_advance_or_load, chip_select_n,
        output chip_select_high, chip_select_third_n, clock_hold_n,
        output out_enable_n, burst_order, byte_write_lane_n,
        output ctl_data, ctl_data_oe,
        input data_bus
    );
    modport mem (
        input addr, wr_n, burst_advance_or_load, chip_select_n,
        input chip_select_high, chip_select_third_n, clock_hold_n,
        input out_enable_n, burst_order, byte_write_lane_n,
        input data_bus,
        output mem_data, mem_data_oe
    );
endinterface

// ---- src/pbs_mem_end.sv ----
// Burst memory port: command pipeline, burst counter and a small array.
// Expects a synchronous controller on the pbs_link_if mem modport.
`timescale 1ns/100ps
module pbs_mem_end #(
    parameter int ADDR_W = pbs_pkg::ADDR_W,
    parameter int MEM_AW = pbs_pkg::MEM_AW
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    pbs_link_if.mem link,
    output logic burst_active_o,
    output logic read_drive_o
);
    localparam int LW = pbs_pkg::LANE_W;
    localparam int NL = pbs_pkg::LANES;
    localparam int DW = pbs_pkg::DATA_W;
    localparam int CW = pbs_pkg::CNT_W;
    localparam int DEPTH = 1 << MEM_AW;

    typedef struct packed {
        logic v;
        logic wr;
        logic [MEM_AW-1:0] a;
        logic [NL-1:0] be;
    } pbs_cmd_t;

    typedef struct packed {
        pbs_cmd_t p1;
        pbs_cmd_t p2;
        logic act;
        logic bwr;
        logic [MEM_AW-CW-1:0] hi;
        logic [CW-1:0] base;
        logic [CW-1:0] cnt;
        logic drive;
        logic [DW-1:0] dout;
        logic [DEPTH-1:0][DW-1:0] mem;
    } pbs_mem_state_t;

    pbs_mem_state_t q;
    pbs_mem_state_t d;

    logic selected;
    logic [CW-1:0] step;
    logic [CW-1:0] word;
    logic [DW-1:0] merged;

    // All three selects must be active for a load
    assign selected = !link.chip_select_n && link.chip_select_high &&
                      !link.chip_select_third_n;
    assign step = q.cnt + 2'h1;
    assign word = (link.burst_order == pbs_pkg::ORDER_INTERLEAVED) ?
                  (q.base ^ step) : (q.base + step);

    always_comb begin
        d = q;
        merged = q.mem[q.p2.a];
        for (int i = 0; i < NL; i++) begin
            if (q.p2.be[i]) begin
                merged[i*LW +: LW] = link.data_bus[i*LW +: LW];
            end
        end
        if (link.clock_hold_n == pbs_pkg::HOLD_RUN) begin
            // Second stage: write data is on the bus now
            if (q.p2.v && q.p2.wr) begin
                d.mem[q.p2.a] = merged;
            end
            // First stage: read data registered for the next edge
            d.drive = q.p1.v && !q.p1.wr;
            if (q.p1.v && !q.p1.wr) begin
                // Bypass so a read right behind a write sees new bytes
                if (q.p2.v && q.p2.wr && q.p2.a == q.p1.a) begin
                    d.dout = merged;
                end else begin
                    d.dout = q.mem[q.p1.a];
                end
            end
            d.p2 = q.p1;
            d.p1 = '0;
            if (!link.burst_advance_or_load) begin
                if (selected) begin
                    d.act = 1'h1;
                    d.bwr = !link.wr_n;
                    d.hi = link.addr[MEM_AW-1:CW];
                    d.base = link.addr[CW-1:0];
                    d.cnt = pbs_pkg::CNT_START;
                    d.p1.v = 1'h1;
                    d.p1.wr = !link.wr_n;
                    d.p1.a = link.addr[MEM_AW-1:0];
                    // Byte selects only count on write cycles
                    d.p1.be = link.wr_n ? '0 : ~link.byte_write_lane_n;
                end else begin
                    d.act = 1'h0;
                end
            end else if (q.act) begin
                d.cnt = step;
                d.act = (step != pbs_pkg::CNT_LAST);
                d.p1.v = 1'h1;
                d.p1.wr = q.bwr;
                d.p1.a = {q.hi, word};
                d.p1.be = q.bwr ? ~link.byte_write_lane_n : '0;
            end
        end
        if (srst_i) begin
            d = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    assign link.mem_data = q.dout;
    // Output enable acts without the clock, so it gates the flop here
    assign link.mem_data_oe = q.drive && !link.out_enable_n;
    assign burst_active_o = q.act;
    assign read_drive_o = q.drive;
endmodule

// ---- src/pbs_ctl_end.sv ----
// Memory controller end: issues loads and bursts, buffers write data.
// Expects the burst memory port on the pbs_link_if ctl modport.
`timescale 1ns/100ps
module pbs_fifo #(
    parameter int WIDTH = pbs_pkg::DATA_W,
    parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int LVW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [LVW-1:0] lvl;
    } pbs_fifo_state_t;

    pbs_fifo_state_t q;
    pbs_fifo_state_t d;
    logic push;
    logic pop;

    assign in_ready_o = (q.lvl != LVW'(DEPTH));
    assign out_valid_o = (q.lvl != '0);
    assign out_data_o = q.mem[q.rp];
    assign level_o = q.lvl;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_i;
            d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.lvl = q.lvl + LVW'(push) - LVW'(pop);
        if (srst_i) begin
            d = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end
endmodule

module pbs_ctl_end #(
    parameter int ADDR_W = pbs_pkg::ADDR_W,
    parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    pbs_link_if.ctl link,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_burst_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [pbs_pkg::LANES-1:0] cmd_byte_en_i,
    output logic cmd_ready_o,
    output logic cmd_wr_ready_o,
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [pbs_pkg::DATA_W-1:0] wdata_i,
    output logic rdata_valid_o,
    output logic [pbs_pkg::DATA_W-1:0] rdata_o,
    input wire logic suspend_i,
    input wire logic out_disable_i,
    input wire logic interleave_i
);
    localparam int DW = pbs_pkg::DATA_W;
    localparam int NL = pbs_pkg::LANES;
    localparam int LVW = $clog2(DEPTH+1);

    typedef enum logic {PBS_IDLE, PBS_BURST} pbs_ctl_mode_t;

    typedef struct packed {
        logic v;
        logic wr;
        logic [DW-1:0] data;
    } pbs_slot_t;

    typedef struct packed {
        pbs_ctl_mode_t mode;
        logic [pbs_pkg::CNT_W-1:0] left;
        logic bwr;
        logic [NL-1:0] be_n;
        pbs_slot_t s0;
        pbs_slot_t s1;
        pbs_slot_t s2;
        logic hold;
        logic [ADDR_W-1:0] addr;
        logic wr_n;
        logic adv;
        logic cs_n;
        logic [NL-1:0] bw_n;
        logic oe_n;
        logic order;
        logic [DW-1:0] wdata;
        logic wdata_oe;
        logic rd_v;
        logic [DW-1:0] rd;
        logic rdy;
        logic wrdy;
    } pbs_ctl_state_t;

    pbs_ctl_state_t q;
    pbs_ctl_state_t d;
    logic take;
    logic pop;
    logic fifo_valid;
    logic [DW-1:0] fifo_data;
    logic [LVW-1:0] level;
    logic [LVW-1:0] level_next;

    pbs_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_wfifo (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .in_valid_i(wdata_valid_i),
        .in_ready_o(wdata_ready_o),
        .in_data_i(wdata_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data),
        .level_o(level)
    );

    assign take = cmd_valid_i && !q.hold && q.mode == PBS_IDLE &&
                  (cmd_write_i ? q.wrdy : q.rdy);
    assign pop = fifo_valid && !q.hold &&
                 (take ? cmd_write_i : (q.mode == PBS_BURST && q.bwr));
    assign level_next = level + LVW'(wdata_valid_i && wdata_ready_o) -
                        LVW'(pop);

    always_comb begin
        d = q;
        d.hold = suspend_i;
        d.oe_n = out_disable_i;
        d.order = interleave_i;
        d.rd_v = 1'h0;
        // The memory ignores an edge seen with hold high, so do we
        if (!q.hold) begin
            d.s1 = q.s0;
            d.s2 = q.s1;
            d.wdata = q.s1.data;
            d.wdata_oe = q.s1.v && q.s1.wr;
            if (q.s2.v && !q.s2.wr) begin
                d.rd_v = 1'h1;
                d.rd = link.data_bus;
            end
            d.s0 = '0;
            d.adv = 1'h0;
            d.cs_n = pbs_pkg::SELECT_IDLE_N;
            d.bw_n = '1;
            case (q.mode)
                PBS_IDLE: begin
                    if (take) begin
                        d.cs_n = 1'h0;
                        d.addr = cmd_addr_i;
                        d.wr_n = !cmd_write_i;
                        d.bwr = cmd_write_i;
                        d.be_n = ~cmd_byte_en_i;
                        d.bw_n = cmd_write_i ? ~cmd_byte_en_i : '1;
                        d.s0 = '{v: 1'h1, wr: cmd_write_i, data: fifo_data};
                        d.left = pbs_pkg::CNT_LAST;
                        d.mode = cmd_burst_i ? PBS_BURST : PBS_IDLE;
                    end
                end
                PBS_BURST: begin
                    d.adv = 1'h1;
                    d.cs_n = 1'h0;
                    d.bw_n = q.bwr ? q.be_n : '1;
                    d.s0 = '{v: 1'h1, wr: q.bwr, data: fifo_data};
                    d.left = q.left - 1'b1;
                    if (q.left == 2'h1) begin
                        d.mode = PBS_IDLE;
                    end
                end
                default: begin
                    d.mode = PBS_IDLE;
                end
            endcase
        end
        // A write is only offered with a whole burst already buffered
        d.rdy = !suspend_i && d.mode == PBS_IDLE;
        d.wrdy = d.rdy && level_next >= LVW'(pbs_pkg::BURST_LEN);
        if (srst_i) begin
            d = '0;
            d.cs_n = pbs_pkg::SELECT_IDLE_N;
            d.wr_n = 1'h1;
            d.bw_n = '1;
            d.oe_n = 1'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        q <= d;
    end

    assign link.addr = q.addr;
    assign link.wr_n = q.wr_n;
    assign link.burst_advance_or_load = q.adv;
    assign link.chip_select_n = q.cs_n;
    assign link.chip_select_high = 1'h1;
    assign link.chip_select_third_n = 1'h0;
    assign link.clock_hold_n = q.hold;
    assign link.out_enable_n = q.oe_n;
    assign link.burst_order = q.order;
    assign link.byte_write_lane_n = q.bw_n;
    assign link.ctl_data = q.wdata;
    assign link.ctl_data_oe = q.wdata_oe;
    assign cmd_ready_o = q.rdy;
    assign cmd_wr_ready_o = q.wrdy;
    assign rdata_valid_o = q.rd_v;
    assign rdata_o = q.rd;
endmodule

// ---- testbench/pbs_link_monitor.sv ----
// Checker for the pins between the controller and the burst memory port.
// Assumes it is instantiated beside the pbs_link_if instance in tb.
`timescale 1ns/100ps
module pbs_link_monitor (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_n,
    input wire logic burst_advance_or_load,
    input wire logic chip_select_n,
    input wire logic chip_select_high,
    input wire logic chip_select_third_n,
    input wire logic clock_hold_n,
    input wire logic out_enable_n,
    input wire logic ctl_data_oe,
    input wire logic [pbs_pkg::DATA_W-1:0] mem_data,
    input wire logic mem_data_oe
);
    default clocking mon_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    logic sel;
    assign sel = !chip_select_n && chip_select_high && !chip_select_third_n;
    sequence go;
        !clock_hold_n && !burst_advance_or_load;
    endsequence
    sequence load_rd;
        go and (sel && wr_n);
    endsequence
    sequence load_wr;
        go and (sel && !wr_n);
    endsequence
    sequence desel;
        go and !sel;
    endsequence
    hold_data_a: assert property (clock_hold_n |=> $stable(mem_data))
        else $error("memory data moved on a held edge");
    hold_drive_a: assert property (clock_hold_n ##1 $stable(out_enable_n)
        |-> $stable(mem_data_oe)) else $error("drive moved on a held edge");
    read_lat_a: assert property (load_rd ##1 !clock_hold_n
        |=> mem_data_oe || out_enable_n) else $error("read data not driven");
    burst_read_a: assert property (load_rd ##1 (!clock_hold_n &&
        burst_advance_or_load) ##1 !clock_hold_n |=> mem_data_oe ||
        out_enable_n) else $error("burst read word not driven");
    write_release_a: assert property (load_wr ##1 !clock_hold_n
        |=> !mem_data_oe) else $error("memory drives in a write slot");
    write_drive_a: assert property (load_wr ##1 !clock_hold_n
        |=> ctl_data_oe) else $error("write data not driven");
    desel_release_a: assert property (desel ##1 !clock_hold_n
        |=> !mem_data_oe) else $error("bus not released after deselect");
    oe_gate_a: assert property (out_enable_n |-> !mem_data_oe)
        else $error("memory drives while output disabled");
    no_clash_a: assert property (!(mem_data_oe && ctl_data_oe))
        else $error("both ends drive the data bus");
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench: controller and memory port joined by pbs_link_if.
// Drives the controller user side at the falling edge; one 10 MHz clock.
`timescale 1ns/100ps
module tb;
    logic ref_clk = 1'h0;
    logic srst = 1'h1;
    logic cv = 1'h0, cw = 1'h0, cb = 1'h0, wv = 1'h0;
    logic sus = 1'h0, odis = 1'h0, ilv = 1'h0;
    logic [pbs_pkg::ADDR_W-1:0] ca = '0;
    logic [3:0] be = 4'h0;
    logic [35:0] wd = '0;
    logic crdy, cwrdy, wrdy, rv;
    logic bact, rdrv;
    logic [35:0] rq;
    logic [35:0] m [64];
    logic [35:0] wq [$];
    logic [8:0] seq = 9'h0;
    int failures = 0;
    int tests_run = 0;

    always #50 ref_clk = ~ref_clk;

    pbs_link_if u_pbs_link_if ();
    pbs_ctl_end u_pbs_ctl_end (.ref_clk_i(ref_clk), .srst_i(srst),
        .link(u_pbs_link_if), .cmd_valid_i(cv), .cmd_write_i(cw),
        .cmd_burst_i(cb), .cmd_addr_i(ca), .cmd_byte_en_i(be),
        .cmd_ready_o(crdy), .cmd_wr_ready_o(cwrdy), .wdata_valid_i(wv),
        .wdata_ready_o(wrdy), .wdata_i(wd), .rdata_valid_o(rv),
        .rdata_o(rq), .suspend_i(sus), .out_disable_i(odis),
        .interleave_i(ilv));
    pbs_mem_end u_pbs_mem_end (.ref_clk_i(ref_clk), .srst_i(srst),
        .link(u_pbs_link_if), .burst_active_o(bact), .read_drive_o(rdrv));
    pbs_link_monitor u_pbs_link_monitor (.ref_clk_i(ref_clk),
        .srst_i(srst), .wr_n(u_pbs_link_if.wr_n),
        .burst_advance_or_load(u_pbs_link_if.burst_advance_or_load),
        .chip_select_n(u_pbs_link_if.chip_select_n),
        .chip_select_high(u_pbs_link_if.chip_select_high),
        .chip_select_third_n(u_pbs_link_if.chip_select_third_n),
        .clock_hold_n(u_pbs_link_if.clock_hold_n),
        .out_enable_n(u_pbs_link_if.out_enable_n),
        .ctl_data_oe(u_pbs_link_if.ctl_data_oe),
        .mem_data(u_pbs_link_if.mem_data),
        .mem_data_oe(u_pbs_link_if.mem_data_oe));

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic hang();
        $display("MISMATCH wait expected 1 seen 0");
        failures++;
        conclude();
    endtask

    function automatic logic [5:0] idx(logic [5:0] a, int k);
        logic [1:0] c;
        c = k[1:0];
        return {a[5:2], ilv ? (a[1:0] ^ c) : (a[1:0] + c)};
    endfunction

    task automatic push();
        int t = 0;
        while (t < 50 && wrdy !== 1'h1) begin
            @(negedge ref_clk);
            t++;
        end
        if (wrdy !== 1'h1) hang();
        seq++;
        wd = 36'h9a5c3e1b7 ^ {4{seq}};
        wv = 1'h1;
        wq.push_back(wd);
        @(negedge ref_clk);
        wv = 1'h0;
        // Let an edge pass so a following push never re-raises valid at once
        @(negedge ref_clk);
    endtask

    task automatic issue(logic w, logic b, logic [5:0] a, logic [3:0] e);
        int t = 0;
        while (t < 50 && (w ? cwrdy : crdy) !== 1'h1) begin
            @(negedge ref_clk);
            t++;
        end
        if ((w ? cwrdy : crdy) !== 1'h1) hang();
        cv = 1'h1;
        cw = w;
        cb = b;
        ca = {12'h0, a};
        be = e;
        @(negedge ref_clk);
        cv = 1'h0;
        @(negedge ref_clk);
    endtask

    task automatic wr(logic b, logic [5:0] a, logic [3:0] e);
        logic [35:0] d;
        logic [5:0] x;
        while (wq.size() < 4) push();
        issue(1'h1, b, a, e);
        for (int k = 0; k < (b ? 4 : 1); k++) begin
            d = wq.pop_front();
            x = idx(a, k);
            for (int l = 0; l < 4; l++) begin
                if (e[l]) m[x][9*l+:9] = d[9*l+:9];
            end
        end
    endtask

    // A set suspend flag holds the link for five cycles mid-transfer
    task automatic rd(logic b, logic [5:0] a, logic s);
        int n = 0;
        int t = 0;
        issue(1'h0, b, a, 4'h0);
        while (n < (b ? 4 : 1) && t < 40) begin
            @(negedge ref_clk);
            t++;
            sus = s && t > 1 && t < 7;
            // One edge after the load the read flop is loaded
            if (t == 1) begin
                chk("read drive", 36'h1, {35'h0, rdrv});
                chk("burst active", {35'h0, b}, {35'h0, bact});
            end
            if (rv === 1'h1) begin
                chk("read word", odis ? '0 : m[idx(a, n)], rq);
                n++;
            end
        end
        if (n < (b ? 4 : 1)) hang();
        chk("burst done", 36'h0, {35'h0, bact});
    endtask

    task automatic rst();
        srst = 1'h1;
        repeat (16) @(negedge ref_clk);
        srst = 1'h0;
        foreach (m[i]) m[i] = '0;
        wq.delete();
    endtask

    task automatic sc_bursts();
        wr(1'h1, 6'h05, 4'hf);
        rd(1'h1, 6'h06, 1'h0);
        ilv = 1'h1;
        repeat (2) @(negedge ref_clk);
        rd(1'h1, 6'h07, 1'h0);
        wr(1'h1, 6'h09, 4'h6);
        rd(1'h1, 6'h08, 1'h1);
        ilv = 1'h0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic sc_lanes();
        for (int l = 0; l < 4; l++) begin
            wr(1'h0, 6'h20, 4'h1 << l);
            rd(1'h0, 6'h20, 1'h0);
        end
    endtask

    // Fill the write buffer to refusal, stall, then drain it empty
    task automatic sc_fifo();
        while (wq.size() < 8) push();
        sus = 1'h1;
        repeat (4) @(negedge ref_clk);
        chk("buffer full ready", 36'h0, {35'h0, wrdy});
        sus = 1'h0;
        wr(1'h1, 6'h30, 4'hf);
        wr(1'h1, 6'h34, 4'hb);
        rd(1'h1, 6'h34, 1'h0);
        chk("buffer empty ready", 36'h1, {35'h0, wrdy});
    endtask

    task automatic sc_out_off();
        odis = 1'h1;
        repeat (3) @(negedge ref_clk);
        rd(1'h1, 6'h30, 1'h0);
        odis = 1'h0;
        repeat (3) @(negedge ref_clk);
        rd(1'h0, 6'h31, 1'h0);
    endtask

    task automatic sc_reset();
        rst();
        rd(1'h1, 6'h05, 1'h0);
    endtask

    initial begin
        rst();
        sc_bursts();
        sc_lanes();
        sc_fifo();
        sc_out_off();
        sc_reset();
        conclude();
    end
endmodule
